// ==== rtcs_core.sv ====
// Status flags, compensation config, free-running counter and seconds
`timescale 1ns/10ps
// Notes on behaviour
// [RULE1] Busy set while buffers copy, then clears
// [RULE2] Busy blocks modulo and config writes
// [RULE3] Hour flag bit 5 on hour increment
// [RULE4] Minute flag bit 4 on minute increment
// [RULE5] Second flag bit 3 on second increment
// [RULE6] Compensation flag bit 2 at second before the final second
// [RULE7] Tick flag bit 0 on quarter ticks
// [RULE8] Write one clears flag; zero keeps
// [RULE9] Interrupt when enabled flag is set
// [RULE10] Reset clears all status bits
// [RULE11] Period select: 5, 15, 30, 60 seconds
// [RULE12] First Q seconds use modulo plus one
// [RULE13] Zero Q never uses modulo plus one
// [RULE14] Count register read-only, resets to zero
// [RULE15] Software reads count twice to confirm
// [RULE16] Modulo is count terminal, resets zero
// [RULE17] Seconds read harmless; write loads counter
// [RULE18] Seconds writes above 59 ignored
// [RULE19] Seconds wrap to zero after 59
// [RULE20] Protection rejects seconds writes
// [RULE21] Protection off after reset
// [RULE22] Each flag has own enable bit
// [RULE23] Hardware set wins over software clear
module rtcs_core
    import rtcs_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    // Time base
    input  wire logic              cnt_tick,
    input  wire logic              comp_enable,
    // Calendar neighbours
    input  wire logic              minute_inc,
    input  wire logic              hour_inc,
    output logic                   second_rollover,
    // Interrupt request
    output logic                   irq
);

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] modulo;
        logic [7:0]  ccr;
        logic [5:0]  sec;
        logic [7:0]  flags;
        logic [7:0]  irq_en;
        logic        protect;
        logic [15:0] rdata;
        logic        rollover;
        logic        irq;
    } rtcs_core_s;

    rtcs_core_s  st;
    rtcs_core_s  next_st;
    rtcs_comp_if cif ();

    logic [16:0] terminal;
    logic        sec_pulse;
    logic        quarter;
    logic [7:0]  set_vec;
    logic [7:0]  clr_vec;
    logic [7:0]  status;
    logic        wr_status;
    logic        wr_sec;

    function automatic logic quarter_hit(input logic [15:0] c, input logic [15:0] m);
        quarter_hit = (c != COUNT_RESET)
                      && (c == (m >> 2) || c == (m >> 1) || c == ((m >> 1) + (m >> 2)));
    endfunction

    function automatic logic is_wr(input logic w, input logic [2:0] a, input logic [2:0] o);
        is_wr = w && (a == o);
    endfunction

    // ********************************************
    // Compensation sequencer
    // ********************************************
    rtcs_comp u_comp (
        .clk  (clk),
        .srst (srst),
        .cif  (cif.comp)
    );

    assign cif.sec_pulse = sec_pulse;
    assign cif.comp_en   = comp_enable;
    assign cif.mod_live  = st.modulo;
    assign cif.ccr_live  = st.ccr;

    // ********************************************
    // Counter terminal and events
    // ********************************************
    assign terminal  = {1'b0, cif.buf_mod} + {16'h0000, cif.plus_one}; // [RULE12]
    assign sec_pulse = cnt_tick && ({1'b0, st.cnt} == terminal); // [RULE16]
    assign quarter   = sec_pulse || (cnt_tick && quarter_hit(st.cnt, cif.buf_mod)); // [RULE7]
    assign status    = st.flags | ({7'h00, cif.busy} << BIT_BUSY);
    assign wr_status = is_wr(wr, addr, OFS_STATUS);
    assign wr_sec    = is_wr(wr, addr, OFS_SECONDS);

    always_comb
    begin
        set_vec = '0;
        set_vec[BIT_HOUR]   = hour_inc; // [RULE3]
        set_vec[BIT_MINUTE] = minute_inc; // [RULE4]
        set_vec[BIT_SECOND] = sec_pulse; // [RULE5]
        set_vec[BIT_COMP]   = cif.comp_last; // [RULE6]
        set_vec[BIT_TICK]   = quarter; // [RULE7]
        clr_vec = wr_status ? (wdata[7:0] & FLAG_MASK) : 8'h00; // [RULE8]
    end

    // ********************************************
    // Next state
    // ********************************************
    always_comb
    begin
        next_st          = st;
        next_st.rdata    = '0;
        next_st.rollover = 1'b0;

        // Free-running counter
        if (cnt_tick)
        begin
            if (sec_pulse)
                next_st.cnt = COUNT_RESET; // [RULE16]
            else
                next_st.cnt = st.cnt + COUNT_ONE;
        end

        // Seconds counter
        if (sec_pulse)
        begin
            if (st.sec == SEC_MAX)
            begin
                next_st.sec      = '0; // [RULE19]
                next_st.rollover = 1'b1;
            end
            else
            begin
                next_st.sec = st.sec + SEC_ONE;
            end
        end
        if (wr_sec && !st.protect && wdata <= 16'(SEC_MAX)) // [RULE18] [RULE20]
            next_st.sec = wdata[5:0]; // [RULE17]

        // Flags: set wins over clear
        next_st.flags = ((st.flags & ~clr_vec) | set_vec) & FLAG_MASK; // [RULE23] [RULE8]

        // Writable registers
        if (!cif.busy) // [RULE2]
        begin
            if (is_wr(wr, addr, OFS_CCR))
                next_st.ccr = wdata[7:0];
            if (is_wr(wr, addr, OFS_MODULO))
                next_st.modulo = wdata; // [RULE16]
        end
        if (is_wr(wr, addr, OFS_IRQ_EN))
            next_st.irq_en = wdata[7:0] & FLAG_MASK; // [RULE22]
        if (is_wr(wr, addr, OFS_PROTECT))
            next_st.protect = wdata[0];

        // Read port
        if (rd)
        begin
            unique case (addr)
                OFS_STATUS:  next_st.rdata = {8'h00, status};
                OFS_CCR:     next_st.rdata = {8'h00, st.ccr};
                OFS_COUNT:   next_st.rdata = st.cnt; // [RULE14]
                OFS_MODULO:  next_st.rdata = st.modulo;
                OFS_SECONDS: next_st.rdata = {10'h000, st.sec}; // [RULE17]
                OFS_IRQ_EN:  next_st.rdata = {8'h00, st.irq_en};
                OFS_PROTECT: next_st.rdata = {15'h0000, st.protect};
                default:     next_st.rdata = '0;
            endcase
        end

        next_st.irq = |(next_st.flags & next_st.irq_en); // [RULE9] [RULE22]
    end

    // ********************************************
    // State register
    // ********************************************
    always_ff @(posedge clk)
    begin
        if (srst)
            st <= '0; // [RULE10] [RULE14] [RULE21]
        else
            st <= next_st;
    end

    assign rdata           = st.rdata;
    assign second_rollover = st.rollover;
    assign irq             = st.irq;

    // ********************************************
    // Checks
    // ********************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_busy_blocks_mod: assert property ( // [RULE2]
        cif.busy && is_wr(wr, addr, OFS_MODULO) |=> st.modulo == $past(st.modulo))
        else $error("modulo written while busy");
    a_hour_flag_set: assert property ( // [RULE3]
        hour_inc |=> st.flags[BIT_HOUR])
        else $error("hour flag missed");
    a_minute_flag_set: assert property ( // [RULE4]
        minute_inc |=> st.flags[BIT_MINUTE])
        else $error("minute flag missed");
    a_second_flag_wins: assert property ( // [RULE5]
        sec_pulse && wr_status && wdata[BIT_SECOND] |=> st.flags[BIT_SECOND])
        else $error("second flag lost to clear");
    a_comp_flag_set: assert property ( // [RULE6]
        cif.comp_last |=> st.flags[BIT_COMP])
        else $error("compensation flag missed");
    a_tick_flag_set: assert property ( // [RULE7]
        quarter |=> st.flags[BIT_TICK])
        else $error("tick flag missed");
    a_w1c_clear: assert property ( // [RULE8]
        wr_status && wdata[BIT_HOUR] && !hour_inc
        |=> !st.flags[BIT_HOUR] && irq == |(st.flags & st.irq_en))
        else $error("write one did not clear");
    a_w0_keeps: assert property ( // [RULE8]
        wr_status && !wdata[BIT_MINUTE] && st.flags[BIT_MINUTE] |=> st.flags[BIT_MINUTE])
        else $error("write zero cleared flag");
    a_irq_gating: assert property ( // [RULE9]
        irq == |(st.flags & st.irq_en))
        else $error("interrupt does not match flags");
    a_reset_clear: assert property (@(posedge clk) disable iff (1'b0) // [RULE10]
        $past(srst) |-> status == 8'h00 && !st.protect)
        else $error("status not clear after reset");
    a_count_ro: assert property ( // [RULE14]
        is_wr(wr, addr, OFS_COUNT) && !cnt_tick |=> st.cnt == $past(st.cnt))
        else $error("count changed by write");
    a_count_wrap: assert property ( // [RULE16]
        sec_pulse |=> st.cnt == COUNT_RESET)
        else $error("count did not wrap at terminal");
    a_sec_load: assert property ( // [RULE17]
        wr_sec && !st.protect && wdata <= 16'(SEC_MAX) |=> st.sec == $past(wdata[5:0]))
        else $error("seconds write not loaded");
    a_sec_range: assert property ( // [RULE18]
        wr_sec && wdata > 16'(SEC_MAX) && !sec_pulse |=> $stable(st.sec))
        else $error("out of range seconds accepted");
    a_sec_wrap: assert property ( // [RULE19]
        sec_pulse && st.sec == SEC_MAX && !wr_sec |=> st.sec == '0 && second_rollover)
        else $error("seconds did not wrap");
    a_sec_protect: assert property ( // [RULE20]
        wr_sec && st.protect && !sec_pulse |=> $stable(st.sec))
        else $error("protected seconds written");

    // ********************************************
    // Register and counter checks
    // ********************************************
    a_ccr_busy_block: assert property ( // [RULE2]
        cif.busy && is_wr(wr, addr, OFS_CCR)
        |=> st.ccr == $past(st.ccr))
        else $error("config written while busy");
    a_mod_write_free: assert property ( // [RULE16]
        !cif.busy && is_wr(wr, addr, OFS_MODULO)
        |=> st.modulo == $past(wdata))
        else $error("modulo write lost");
    a_ccr_write_free: assert property ( // [RULE11]
        !cif.busy && is_wr(wr, addr, OFS_CCR)
        |=> st.ccr == $past(wdata[7:0]))
        else $error("config write lost");
    a_status_spare_zero: assert property ( // [RULE10]
        (status & ~(FLAG_MASK | (8'h01 << BIT_BUSY)))
        == 8'h00)
        else $error("spare status bit set");
    a_minute_w1c: assert property ( // [RULE8]
        wr_status && wdata[BIT_MINUTE] && !minute_inc
        |=> !st.flags[BIT_MINUTE])
        else $error("minute flag not cleared");
    a_second_w1c: assert property ( // [RULE8]
        wr_status && wdata[BIT_SECOND] && !sec_pulse
        |=> !st.flags[BIT_SECOND])
        else $error("second flag not cleared");
    a_comp_w1c: assert property ( // [RULE8]
        wr_status && wdata[BIT_COMP] && !cif.comp_last
        |=> !st.flags[BIT_COMP])
        else $error("compensation flag not cleared");
    a_tick_w1c: assert property ( // [RULE8]
        wr_status && wdata[BIT_TICK] && !quarter
        |=> !st.flags[BIT_TICK])
        else $error("tick flag not cleared");
    a_flag_hold: assert property ( // [RULE8]
        !wr_status && set_vec == 8'h00
        |=> st.flags == $past(st.flags))
        else $error("flag changed without cause");
    a_irq_en_write: assert property ( // [RULE22]
        is_wr(wr, addr, OFS_IRQ_EN)
        |=> st.irq_en == ($past(wdata[7:0]) & FLAG_MASK))
        else $error("enable write lost");
    a_irq_masked: assert property ( // [RULE22]
        st.irq_en == 8'h00
        |-> !irq)
        else $error("interrupt with no enable");
    a_count_step: assert property ( // [RULE16]
        cnt_tick && !sec_pulse
        |=> st.cnt == $past(st.cnt) + COUNT_ONE)
        else $error("count did not step");
    a_count_idle: assert property ( // [RULE14]
        !cnt_tick
        |=> $stable(st.cnt))
        else $error("count moved without tick");
    a_term_plain: assert property ( // [RULE12]
        cnt_tick && !cif.plus_one && st.cnt == cif.buf_mod
        |-> sec_pulse)
        else $error("plain terminal missed");
    a_term_plus: assert property ( // [RULE12]
        cnt_tick && cif.plus_one && st.cnt == cif.buf_mod
        |-> !sec_pulse)
        else $error("plus one terminal ended early");
    a_plus_needs_en: assert property ( // [RULE13]
        !comp_enable
        |-> !cif.plus_one)
        else $error("plus one without compensation");
    a_sec_step: assert property ( // [RULE17]
        sec_pulse && st.sec != SEC_MAX && !wr_sec
        |=> st.sec == $past(st.sec) + SEC_ONE)
        else $error("seconds did not step");
    a_sec_read_safe: assert property ( // [RULE17]
        rd && !sec_pulse && !wr_sec
        |=> $stable(st.sec))
        else $error("seconds disturbed by read");
    a_roll_only_wrap: assert property ( // [RULE19]
        sec_pulse && st.sec != SEC_MAX
        |=> !second_rollover)
        else $error("rollover without wrap");
    a_status_read: assert property ( // [RULE10]
        rd && addr == OFS_STATUS
        |=> rdata == {8'h00, $past(status)})
        else $error("status read wrong");
    a_comp_gated: assert property ( // [RULE6]
        !comp_enable
        |-> !cif.comp_last)
        else $error("compensation flag without compensation");

    c_sec_rollover: cover property (sec_pulse && st.sec == SEC_MAX);
    c_comp_last: cover property (cif.comp_last ##1 st.flags[BIT_COMP]);
    c_busy_write: cover property (cif.busy && is_wr(wr, addr, OFS_CCR));
    c_irq_raise: cover property (!irq ##1 irq);
    c_plus_second: cover property (cif.plus_one && sec_pulse);

endmodule // rtcs_core

// ==== rtcs_pkg.sv ====
// Shared constants for the seconds, status and compensation block
package rtcs_pkg;

    // ********************************************
    // Bus geometry
    // ********************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;

    // ********************************************
    // Register offsets
    // ********************************************
    localparam logic [2:0] OFS_STATUS  = 3'h0;
    localparam logic [2:0] OFS_CCR     = 3'h1;
    localparam logic [2:0] OFS_COUNT   = 3'h2;
    localparam logic [2:0] OFS_MODULO  = 3'h3;
    localparam logic [2:0] OFS_SECONDS = 3'h4;
    localparam logic [2:0] OFS_IRQ_EN  = 3'h5;
    localparam logic [2:0] OFS_PROTECT = 3'h6;

    // ********************************************
    // Status and enable bit positions
    // ********************************************
    localparam int BIT_BUSY   = 7;
    localparam int BIT_HOUR   = 5;
    localparam int BIT_MINUTE = 4;
    localparam int BIT_SECOND = 3;
    localparam int BIT_COMP   = 2;
    localparam int BIT_TICK   = 0;
    localparam logic [7:0] FLAG_MASK = 8'h3d;

    // ********************************************
    // Compensation config fields and periods
    // ********************************************
    localparam int CCS_MSB = 7;
    localparam int CCS_LSB = 6;
    localparam int Q_MSB   = 5;
    localparam logic [5:0] COMP_PER_5S  = 6'h05;
    localparam logic [5:0] COMP_PER_15S = 6'h0f;
    localparam logic [5:0] COMP_PER_30S = 6'h1e;
    localparam logic [5:0] COMP_PER_60S = 6'h3c;

    // ********************************************
    // Seconds range and reset values
    // ********************************************
    localparam logic [5:0]  SEC_MAX     = 6'h3b;
    localparam logic [5:0]  SEC_ONE     = 6'h01;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ONE   = 16'h0001;

    typedef enum logic [1:0] {
        RTCS_PH_START = 2'b00,
        RTCS_PH_LOAD  = 2'b01,
        RTCS_PH_RUN   = 2'b10
    } rtcs_phase_e;

endpackage

// ==== rtcs_comp_if.sv ====
// Link between the register/counter core and the compensation sequencer
`timescale 1ns/10ps
interface rtcs_comp_if;
    logic        sec_pulse;
    logic        comp_en;
    logic [15:0] mod_live;
    logic [7:0]  ccr_live;
    logic        busy;
    logic        plus_one;
    logic        comp_last;
    logic [15:0] buf_mod;

    modport core (output sec_pulse, comp_en, mod_live, ccr_live,
                  input busy, plus_one, comp_last, buf_mod);
    modport comp (input sec_pulse, comp_en, mod_live, ccr_live,
                  output busy, plus_one, comp_last, buf_mod);
endinterface

// ==== rtcs_comp.sv ====
// Compensation sequencer with buffered modulo and config
`timescale 1ns/10ps
module rtcs_comp
    import rtcs_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Core link
    rtcs_comp_if.comp cif
);

    typedef struct packed {
        rtcs_phase_e phase;
        logic [15:0] buf_mod;
        logic [7:0]  buf_ccr;
        logic [5:0]  sec_idx;
    } rtcs_comp_s;

    rtcs_comp_s st;
    rtcs_comp_s next_st;
    logic [5:0] last_idx;

    function automatic logic [5:0] period_of(input logic [1:0] ccs);
        unique case (ccs)
            2'b00: period_of = COMP_PER_5S;
            2'b01: period_of = COMP_PER_15S;
            2'b10: period_of = COMP_PER_30S;
            2'b11: period_of = COMP_PER_60S;
        endcase
    endfunction

    // ********************************************
    // Sequencing
    // ********************************************
    always_comb
    begin
        next_st  = st;
        last_idx = period_of(st.buf_ccr[CCS_MSB:CCS_LSB]) - SEC_ONE; // [RULE11]
        unique case (st.phase)
            RTCS_PH_START: next_st.phase = RTCS_PH_LOAD;
            RTCS_PH_LOAD:
            begin
                next_st.buf_mod = cif.mod_live; // [RULE1]
                next_st.buf_ccr = cif.ccr_live;
                next_st.phase   = RTCS_PH_RUN;
            end
            RTCS_PH_RUN: next_st.phase = RTCS_PH_RUN;
            default: next_st.phase = RTCS_PH_START;
        endcase
        if (cif.sec_pulse)
        begin
            if (st.sec_idx >= last_idx)
            begin
                next_st.sec_idx = '0;
                next_st.phase   = RTCS_PH_LOAD;
            end
            else
            begin
                next_st.sec_idx = st.sec_idx + SEC_ONE;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st <= '0;
        else
            st <= next_st;
    end

    assign cif.busy      = (st.phase == RTCS_PH_LOAD); // [RULE1]
    assign cif.buf_mod   = st.buf_mod;
    assign cif.plus_one  = cif.comp_en && (st.sec_idx < st.buf_ccr[Q_MSB:0]); // [RULE12] [RULE13]
    assign cif.comp_last = cif.comp_en && cif.sec_pulse
                           && (st.sec_idx == last_idx - SEC_ONE); // [RULE6]

    // ********************************************
    // Checks
    // ********************************************
    a_busy_single: assert property (@(posedge clk) disable iff (srst) // [RULE1]
        cif.busy |=> !cif.busy && st.buf_mod == $past(cif.mod_live))
        else $error("busy not one cycle or buffer not copied");
    a_plus_zero: assert property (@(posedge clk) disable iff (srst) // [RULE13]
        st.buf_ccr[Q_MSB:0] == '0 |-> !cif.plus_one)
        else $error("plus one used with zero count");

endmodule // rtcs_comp

// ==== test_rtcs_core.sv ====
// Self-checking bench for the seconds, status and compensation block
`timescale 1ns/10ps
module test_rtcs_core
    import rtcs_pkg::*;
;
    // ********************************************
    // Stimulus and observation
    // ********************************************
    logic              clk         = 1'b0;
    logic              srst        = 1'b1;
    logic [ADDR_W-1:0] addr        = '0;
    logic [DATA_W-1:0] wdata       = '0;
    logic              wr          = 1'b0;
    logic              rd          = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              cnt_tick    = 1'b0;
    logic              comp_enable = 1'b0;
    logic              minute_inc  = 1'b0;
    logic              hour_inc    = 1'b0;
    logic              second_rollover;
    logic              irq;
    int                n_fail      = 0;
    int                cmp_count   = 0;
    int                n_roll      = 0;
    int                k           = 0;
    int                nb          = 0;
    int                n           = 0;
    logic [15:0]       v;
    logic [7:0]        bs [0:5];
    logic [5:0]        per;

    always #12.5 clk = ~clk;

    rtcs_core dut_u (
        .clk             (clk),
        .srst            (srst),
        .addr            (addr),
        .wdata           (wdata),
        .wr              (wr),
        .rd              (rd),
        .rdata           (rdata),
        .cnt_tick        (cnt_tick),
        .comp_enable     (comp_enable),
        .minute_inc      (minute_inc),
        .hour_inc        (hour_inc),
        .second_rollover (second_rollover),
        .irq             (irq)
    );

    always @(posedge clk)
        if (second_rollover === 1'b1)
            n_roll <= n_roll + 1;

    // ********************************************
    // Bus, tick and checking tasks
    // ********************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic expect_reg(input logic [2:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd_reg(a, d);
        check(d, e);
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({15'h0, irq}, {15'h0, e});
    endtask

    task automatic tick();
        @(posedge clk);
        cnt_tick <= 1'b1;
        @(posedge clk);
        cnt_tick <= 1'b0;
    endtask

    // Status read on six back-to-back cycles, busy cycles counted
    task automatic burst();
        nb = 0;
        rd <= 1'b1;
        addr <= OFS_STATUS;
        for (int j = 0; j < 6; j++)
        begin
            @(posedge clk);
            @(negedge clk);
            bs[j] = rdata[7:0];
            if (rdata[BIT_BUSY] === 1'b1)
            begin
                nb++;
                k = j;
            end
        end
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic until_comp();
        n = 0;
        v = '0;
        while (v[BIT_COMP] !== 1'b1 && n < 200)
        begin
            tick();
            rd_reg(OFS_STATUS, v);
            n++;
        end
    endtask

    task automatic do_reset();
        srst <= 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
    endtask

    task automatic conclude();
        if (n_fail == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ********************************************
    // Watchdog
    // ********************************************
    initial
    begin
        repeat (40000) @(posedge clk);
        n_fail++;
        conclude();
    end

    // ********************************************
    // Test sequence
    // ********************************************
    initial
    begin
        do_reset();
        burst();
        check({8'h00, bs[0]}, 16'h0000);
        check(16'(nb), 16'h0001);
        for (int i = 0; i < 2; i++)
        begin
            do_reset();
            repeat (k) @(posedge clk);
            wr <= 1'b1;
            addr <= (i == 0) ? OFS_MODULO : OFS_CCR;
            wdata <= 16'h0005;
            @(posedge clk);
            wr <= 1'b0;
            expect_reg((i == 0) ? OFS_MODULO : OFS_CCR, 16'h0000);
        end
        for (int a = 0; a < 7; a++)
            expect_reg(3'(a), 16'h0000);
        wr_reg(OFS_MODULO, 16'hbeef);
        expect_reg(OFS_MODULO, 16'hbeef);
        wr_reg(OFS_MODULO, 16'h0000);
        wr_reg(OFS_COUNT, 16'h1234);
        expect_reg(OFS_COUNT, 16'h0000);
        wr_reg(OFS_STATUS, 16'h0080);
        expect_reg(OFS_STATUS, 16'h0000);
        wr_reg(OFS_CCR, 16'h00c5);
        expect_reg(OFS_CCR, 16'h00c5);
        wr_reg(OFS_CCR, 16'h0000);
        wr_reg(3'h7, 16'hffff);
        expect_reg(3'h7, 16'h0000);
        // Seconds load, range, protection and wrap
        wr_reg(OFS_SECONDS, 16'h000a);
        expect_reg(OFS_SECONDS, 16'h000a);
        wr_reg(OFS_SECONDS, 16'h003c);
        expect_reg(OFS_SECONDS, 16'h000a);
        wr_reg(OFS_PROTECT, 16'h0001);
        wr_reg(OFS_SECONDS, 16'h0005);
        expect_reg(OFS_SECONDS, 16'h000a);
        wr_reg(OFS_PROTECT, 16'h0000);
        wr_reg(OFS_SECONDS, 16'h003b);
        tick();
        expect_reg(OFS_SECONDS, 16'h0000);
        check(16'(n_roll), 16'h0001);
        // Flags, clearing and interrupt gating
        expect_reg(OFS_STATUS, 16'h0009);
        wr_reg(OFS_STATUS, 16'h0000);
        expect_reg(OFS_STATUS, 16'h0009);
        wr_reg(OFS_STATUS, 16'h0001);
        expect_reg(OFS_STATUS, 16'h0008);
        @(posedge clk);
        minute_inc <= 1'b1;
        hour_inc <= 1'b1;
        @(posedge clk);
        minute_inc <= 1'b0;
        hour_inc <= 1'b0;
        expect_reg(OFS_STATUS, 16'h0038);
        for (int b = 3; b < 6; b++)
        begin
            wr_reg(OFS_IRQ_EN, 16'(1 << b));
            expect_reg(OFS_IRQ_EN, 16'(1 << b));
            irq_is(1'b1);
            wr_reg(OFS_STATUS, 16'(1 << b));
            irq_is(1'b0);
        end
        expect_reg(OFS_STATUS, 16'h0000);
        // Compensation periods, plus-one seconds and reload
        @(posedge clk);
        comp_enable <= 1'b1;
        wr_reg(OFS_IRQ_EN, 16'h0004);
        for (int c = 3; c >= 0; c--)
        begin
            wr_reg(OFS_MODULO, (c == 0) ? 16'h0002 : 16'h0000);
            wr_reg(OFS_CCR, {8'h00, c[1:0], (c == 0) ? 6'h03 : 6'h00});
            until_comp();
            irq_is(1'b1);
            wr_reg(OFS_STATUS, 16'h0004);
            irq_is(1'b0);
            // Finish the last second of the cycle to reach the reload
            repeat ((c == 0) ? 3 : 1) tick();
            burst();
            check(16'(nb), 16'h0001);
            until_comp();
            per = (c == 3) ? COMP_PER_60S : (c == 2) ? COMP_PER_30S : COMP_PER_15S;
            check(16'(n), (c == 0) ? 16'h000f : {10'h0, per - SEC_ONE});
            wr_reg(OFS_STATUS, 16'h0004);
        end
        rd_reg(OFS_COUNT, v);
        expect_reg(OFS_COUNT, v);
        conclude();
    end
endmodule // test_rtcs_core
